// ### design/crs_pkg.sv
/*
  Constants, field layouts, command codes and carrier types shared by the
  register set of an 8-bit core and its arithmetic helper.
  Assumes a single 40 MHz clock and an APB master reaching 32-bit words.
*/
// Operation
// RULE_01: Eight-bit work register for transfers and tests.
// RULE_02: Work and second index pair as word.
// RULE_03: Second index is high byte, work low.
// RULE_04: Indexed address adds index to given address.
// RULE_05: Index registers increment, decrement, compare, transfer.
// RULE_06: Eight-bit stack pointer selects save location.
// RULE_07: Calls and interrupts update stack pointer automatically.
// RULE_08: Stack lives in page one, 0x100-0x1FF.
// RULE_09: Push writes then decrements; pop increments then reads.
// RULE_10: Reset leaves stack pointer untouched.
// RULE_11: Software loads stack pointer first, normally 0xFF.
// RULE_12: Sixteen-bit fetch address from two byte halves.
// RULE_13: Reset holds fetch address at 0xFFFE.
// RULE_14: Flag word holds N, V, B, H, I, Z, C.
// RULE_15: Carry takes ALU carry, shifts and rotates.
// RULE_16: Zero set on zero result, else cleared.
// RULE_17: Interrupt enable set, cleared, cleared on service.
// RULE_18: Half carry from bit 3 or no borrow bit 4.
// RULE_19: Overflow on signed overflow; bit test copies bit 6.
// RULE_20: Negative follows bit 7; bit test copies bit 7.
package crs_pkg;

  // Register word offsets on the APB bus.
  localparam logic [7:0] OFF_WORK = 8'h00;
  localparam logic [7:0] OFF_IDX_X = 8'h04;
  localparam logic [7:0] OFF_IDX_Y = 8'h08;
  localparam logic [7:0] OFF_PAIR = 8'h0c;
  localparam logic [7:0] OFF_STACK = 8'h10;
  localparam logic [7:0] OFF_FETCH_HI = 8'h14;
  localparam logic [7:0] OFF_FETCH_LO = 8'h18;
  localparam logic [7:0] OFF_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_CMD = 8'h20;
  localparam logic [7:0] OFF_EA = 8'h24;
  localparam logic [7:0] OFF_STK_ADDR = 8'h28;

  // Reset values.
  localparam logic [7:0] RST_FETCH_HI = 8'hff;
  localparam logic [7:0] RST_FETCH_LO = 8'hfe;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Stack page number placed above the stack pointer.
  localparam logic [7:0] STACK_PAGE = 8'h01;

  // Flag word bit positions.
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_I = 2;
  localparam int unsigned FLG_H = 3;
  localparam int unsigned FLG_B = 4;
  localparam int unsigned FLG_G = 5;
  localparam int unsigned FLG_V = 6;
  localparam int unsigned FLG_N = 7;

  // Register selector codes of a command.
  localparam logic [1:0] SEL_WORK = 2'h0;
  localparam logic [1:0] SEL_IDX_X = 2'h1;
  localparam logic [1:0] SEL_IDX_Y = 2'h2;
  localparam logic [1:0] SEL_FLAGS = 2'h3;

  // Operations started by a write to the command register.
  typedef enum logic [4:0] {
    OP_NOP, OP_LD, OP_INC, OP_DEC, OP_CMP, OP_ADC, OP_SBC, OP_ASL,
    OP_ROR, OP_BIT, OP_INDEX, OP_PUSH, OP_POP, OP_CALL, OP_IRQ, OP_BRK,
    OP_RET, OP_RETI, OP_IRQ_ON, OP_IRQ_OFF, OP_CLRV, OP_LDW, OP_INCW
  } crs_op_e;

  // Layout of the command register.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] imm;
    logic rsv;
    logic [1:0] sel;
    logic [4:0] op;
  } crs_cmd_s;

  // Resettable state of the register set.
  typedef struct packed {
    logic [7:0] work;
    logic [7:0] idx_x;
    logic [7:0] idx_y;
    logic [7:0] fetch_hi;
    logic [7:0] fetch_lo;
    logic [7:0] flags;
    logic [15:0] ea;
    logic [15:0] stk_addr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } crs_state_s;

endpackage : crs_pkg

// ### design/crs_alu.sv
/*
  Arithmetic helper of the register set: add, subtract, compare,
  increment, decrement, shift and rotate on one byte with flag outputs.
  Assumes the caller picks which flags to keep for each operation.
*/
`timescale 1ns/100ps
module crs_alu (
  input wire crs_pkg::crs_op_e op,
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic cin,
  output logic [7:0] res,
  output logic co,
  output logic ho,
  output logic vo
);

  logic [7:0] b;
  logic c0;
  logic [4:0] lo;
  logic [8:0] sum;

  // Subtraction adds the complement, so carry set means no borrow.
  always_comb begin
    b = opb;
    c0 = cin;
    case (op)
      crs_pkg::OP_SBC: begin
        b = ~opb;
      end
      crs_pkg::OP_CMP: begin
        b = ~opb;
        c0 = 1'b1;
      end
      crs_pkg::OP_INC: begin
        b = 8'h00;
        c0 = 1'b1;
      end
      crs_pkg::OP_DEC: begin
        b = 8'hff;
        c0 = 1'b0;
      end
      default: begin
        b = opb;
      end
    endcase
    lo = {1'b0, opa[3:0]} + {1'b0, b[3:0]} + {4'h0, c0};
    sum = {1'b0, opa} + {1'b0, b} + {8'h00, c0};
    res = sum[7:0];
    co = sum[8]; // see RULE_15
    ho = lo[4]; // see RULE_18
    vo = (opa[7] == b[7]) && (sum[7] != opa[7]); // see RULE_19
    case (op)
      crs_pkg::OP_ASL: begin
        res = {opa[6:0], 1'b0};
        co = opa[7]; // see RULE_15
      end
      crs_pkg::OP_ROR: begin
        res = {cin, opa[7:1]};
        co = opa[0]; // see RULE_15
      end
      default: begin
        res = sum[7:0];
      end
    endcase
  end

endmodule : crs_alu

// ### design/crs_register_set.sv
/*
  Architectural register set of an 8-bit core: work register, two index
  registers, the pairing of work and second index into a word, stack pointer over page one,
  16-bit fetch address and flag word, reached over APB.
  Assumes an APB3 master on pclk and that stack page one is owned here.
*/
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module crs_register_set (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] pair_word_reg,
  output logic [15:0] next_fetch_addr,
  output logic [7:0] flag_word,
  output logic [15:0] eff_addr,
  output logic [15:0] stk_addr
);

  crs_pkg::crs_state_s r;
  crs_pkg::crs_state_s next_r;
  logic [7:0] stack_ptr;
  logic [7:0] next_stack_ptr;
  logic [7:0] stack_mem [0:255];
  logic [2:0] stk_we;
  logic [7:0] stk_wa [0:2];
  logic [7:0] stk_wd [0:2];
  crs_pkg::crs_cmd_s cmd;
  crs_pkg::crs_op_e op;
  logic [7:0] opd;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_h;
  logic alu_v;
  logic wr_go;
  logic [15:0] wide;

  // Tells whether an offset names a register of this block.
  function automatic logic crs_hit(input logic [7:0] a);
    case (a)
      crs_pkg::OFF_WORK, crs_pkg::OFF_IDX_X, crs_pkg::OFF_IDX_Y,
      crs_pkg::OFF_PAIR, crs_pkg::OFF_STACK, crs_pkg::OFF_FETCH_HI,
      crs_pkg::OFF_FETCH_LO, crs_pkg::OFF_FLAGS, crs_pkg::OFF_CMD,
      crs_pkg::OFF_EA, crs_pkg::OFF_STK_ADDR: crs_hit = 1'b1;
      default: crs_hit = 1'b0;
    endcase
  endfunction : crs_hit

  // Reads the byte register chosen by a selector.
  function automatic logic [7:0] crs_get(input crs_pkg::crs_state_s s,
                                          input logic [1:0] sel);
    case (sel)
      crs_pkg::SEL_WORK: crs_get = s.work;
      crs_pkg::SEL_IDX_X: crs_get = s.idx_x;
      crs_pkg::SEL_IDX_Y: crs_get = s.idx_y;
      default: crs_get = s.flags;
    endcase
  endfunction : crs_get

  // Returns the state with the selected byte register replaced.
  function automatic crs_pkg::crs_state_s crs_put(
      input crs_pkg::crs_state_s s, input logic [1:0] sel,
      input logic [7:0] v);
    crs_pkg::crs_state_s t;
    t = s;
    case (sel)
      crs_pkg::SEL_WORK: t.work = v;
      crs_pkg::SEL_IDX_X: t.idx_x = v;
      crs_pkg::SEL_IDX_Y: t.idx_y = v;
      default: t.flags = v;
    endcase
    crs_put = t;
  endfunction : crs_put

  // Returns the state with negative and zero taken from a result.
  function automatic crs_pkg::crs_state_s crs_nz(
      input crs_pkg::crs_state_s s, input logic [7:0] v);
    crs_pkg::crs_state_s t;
    t = s;
    t.flags[crs_pkg::FLG_N] = v[7]; // see RULE_20
    t.flags[crs_pkg::FLG_Z] = (v == 8'h00); // see RULE_16
    crs_nz = t;
  endfunction : crs_nz

  // Command fields and the operand the command works on.
  assign cmd = crs_pkg::crs_cmd_s'(pwdata);
  assign op = crs_pkg::crs_op_e'(cmd.op);
  assign opd = crs_get(r, cmd.sel);
  assign wr_go = psel && penable && pwrite && r.pready;

  crs_alu u_alu (
    .op(op),
    .opa(opd),
    .opb(cmd.imm),
    .cin(r.flags[crs_pkg::FLG_C]),
    .res(alu_res),
    .co(alu_c),
    .ho(alu_h),
    .vo(alu_v)
  );

  // Next state: bus answer, register writes and command execution.
  always_comb begin
    next_r = r;
    next_stack_ptr = stack_ptr;
    stk_we = 3'h0;
    wide = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      stk_wa[i] = 8'h00;
      stk_wd[i] = 8'h00;
    end
    // Zero-wait answer: ready in the first access cycle.
    next_r.pready = psel && !penable;
    next_r.pslverr = psel && !penable && !crs_hit(paddr);
    if (psel && !penable) begin
      case (paddr)
        crs_pkg::OFF_WORK: next_r.prdata = {24'h0, r.work};
        crs_pkg::OFF_IDX_X: next_r.prdata = {24'h0, r.idx_x};
        crs_pkg::OFF_IDX_Y: next_r.prdata = {24'h0, r.idx_y};
        crs_pkg::OFF_PAIR: next_r.prdata = {16'h0, r.idx_y, r.work};
        crs_pkg::OFF_STACK: next_r.prdata = {24'h0, stack_ptr};
        crs_pkg::OFF_FETCH_HI: next_r.prdata = {24'h0, r.fetch_hi};
        crs_pkg::OFF_FETCH_LO: next_r.prdata = {24'h0, r.fetch_lo};
        crs_pkg::OFF_FLAGS: next_r.prdata = {24'h0, r.flags};
        crs_pkg::OFF_EA: next_r.prdata = {16'h0, r.ea};
        crs_pkg::OFF_STK_ADDR: next_r.prdata = {16'h0, r.stk_addr};
        default: next_r.prdata = 32'h0;
      endcase
    end
    if (wr_go) begin
      case (paddr)
        crs_pkg::OFF_WORK: next_r.work = pwdata[7:0]; // see RULE_01
        crs_pkg::OFF_IDX_X: next_r.idx_x = pwdata[7:0];
        crs_pkg::OFF_IDX_Y: next_r.idx_y = pwdata[7:0];
        crs_pkg::OFF_PAIR: begin
          next_r.idx_y = pwdata[15:8]; // see RULE_03
          next_r.work = pwdata[7:0]; // see RULE_02
        end
        crs_pkg::OFF_STACK: next_stack_ptr = pwdata[7:0]; // see RULE_11
        crs_pkg::OFF_FETCH_HI: next_r.fetch_hi = pwdata[7:0]; // see RULE_12
        crs_pkg::OFF_FETCH_LO: next_r.fetch_lo = pwdata[7:0]; // see RULE_12
        crs_pkg::OFF_FLAGS: next_r.flags = pwdata[7:0]; // see RULE_14
        crs_pkg::OFF_CMD: begin
          case (op)
            crs_pkg::OP_LD: begin
              next_r = crs_nz(crs_put(r, cmd.sel, cmd.imm),
                              cmd.imm); // see RULE_05
            end
            crs_pkg::OP_INC, crs_pkg::OP_DEC, crs_pkg::OP_ASL,
            crs_pkg::OP_ROR: begin
              next_r = crs_nz(crs_put(r, cmd.sel, alu_res),
                              alu_res); // see RULE_05
              if (op == crs_pkg::OP_ASL || op == crs_pkg::OP_ROR) begin
                next_r.flags[crs_pkg::FLG_C] = alu_c; // see RULE_15
              end
            end
            crs_pkg::OP_CMP: begin
              next_r = crs_nz(r, alu_res); // see RULE_05
              next_r.flags[crs_pkg::FLG_C] = alu_c;
            end
            crs_pkg::OP_ADC, crs_pkg::OP_SBC: begin
              next_r = crs_nz(crs_put(r, cmd.sel, alu_res), alu_res);
              next_r.flags[crs_pkg::FLG_C] = alu_c; // see RULE_15
              next_r.flags[crs_pkg::FLG_H] = alu_h; // see RULE_18
              next_r.flags[crs_pkg::FLG_V] = alu_v; // see RULE_19
            end
            crs_pkg::OP_BIT: begin
              next_r.flags[crs_pkg::FLG_N] = cmd.imm[7]; // see RULE_20
              next_r.flags[crs_pkg::FLG_V] = cmd.imm[6]; // see RULE_19
              next_r.flags[crs_pkg::FLG_Z] =
                ((r.work & cmd.imm) == 8'h00); // see RULE_16
            end
            crs_pkg::OP_INDEX: begin
              next_r.ea = cmd.addr + {8'h00, opd}; // see RULE_04
            end
            crs_pkg::OP_PUSH: begin
              stk_we[0] = 1'b1; // see RULE_09
              stk_wa[0] = stack_ptr;
              stk_wd[0] = opd;
              next_stack_ptr = stack_ptr - 8'h01;
              next_r.stk_addr = {crs_pkg::STACK_PAGE, stack_ptr};
            end
            crs_pkg::OP_POP: begin
              next_stack_ptr = stack_ptr + 8'h01; // see RULE_09
              next_r = crs_put(r, cmd.sel, stack_mem[next_stack_ptr]);
              next_r.stk_addr = {crs_pkg::STACK_PAGE, next_stack_ptr};
            end
            crs_pkg::OP_CALL, crs_pkg::OP_IRQ, crs_pkg::OP_BRK: begin
              // Return address high byte goes deepest.
              stk_we = 3'h3; // see RULE_07
              stk_wa[0] = stack_ptr;
              stk_wd[0] = r.fetch_hi;
              stk_wa[1] = stack_ptr - 8'h01;
              stk_wd[1] = r.fetch_lo;
              next_stack_ptr = stack_ptr - 8'h02;
              if (op != crs_pkg::OP_CALL) begin
                stk_we[2] = 1'b1;
                stk_wa[2] = stack_ptr - 8'h02;
                stk_wd[2] = r.flags;
                if (op == crs_pkg::OP_BRK) begin
                  stk_wd[2][crs_pkg::FLG_B] = 1'b1;
                  next_r.flags[crs_pkg::FLG_B] = 1'b1;
                end
                next_stack_ptr = stack_ptr - 8'h03;
                next_r.flags[crs_pkg::FLG_I] = 1'b0; // see RULE_17
              end
              next_r.stk_addr = {crs_pkg::STACK_PAGE,
                                 next_stack_ptr}; // see RULE_08
              {next_r.fetch_hi, next_r.fetch_lo} = cmd.addr;
            end
            crs_pkg::OP_RET: begin
              next_r.fetch_lo = stack_mem[stack_ptr + 8'h01];
              next_r.fetch_hi = stack_mem[stack_ptr + 8'h02];
              next_stack_ptr = stack_ptr + 8'h02; // see RULE_09
              next_r.stk_addr = {crs_pkg::STACK_PAGE, next_stack_ptr};
            end
            crs_pkg::OP_RETI: begin
              next_r.flags = stack_mem[stack_ptr + 8'h01];
              next_r.fetch_lo = stack_mem[stack_ptr + 8'h02];
              next_r.fetch_hi = stack_mem[stack_ptr + 8'h03];
              next_stack_ptr = stack_ptr + 8'h03; // see RULE_07
              next_r.stk_addr = {crs_pkg::STACK_PAGE, next_stack_ptr};
            end
            crs_pkg::OP_IRQ_ON: begin
              next_r.flags[crs_pkg::FLG_I] = 1'b1; // see RULE_17
            end
            crs_pkg::OP_IRQ_OFF: begin
              next_r.flags[crs_pkg::FLG_I] = 1'b0; // see RULE_17
            end
            crs_pkg::OP_CLRV: begin
              next_r.flags[crs_pkg::FLG_V] = 1'b0;
              next_r.flags[crs_pkg::FLG_H] = 1'b0;
            end
            crs_pkg::OP_LDW: begin
              {next_r.idx_y, next_r.work} = cmd.addr; // see RULE_02
              next_r.flags[crs_pkg::FLG_N] = cmd.addr[15];
              next_r.flags[crs_pkg::FLG_Z] = (cmd.addr == 16'h0000);
            end
            crs_pkg::OP_INCW: begin
              wide = {r.idx_y, r.work} + 16'h0001; // see RULE_03
              {next_r.idx_y, next_r.work} = wide;
              next_r.flags[crs_pkg::FLG_N] = wide[15];
              next_r.flags[crs_pkg::FLG_Z] = (wide == 16'h0000);
            end
            default: begin
              next_r.ea = r.ea;
            end
          endcase
        end
        default: begin
          next_r.ea = r.ea;
        end
      endcase
    end
  end

  // Control state with its reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.work <= crs_pkg::RST_BYTE;
      r.idx_x <= crs_pkg::RST_BYTE;
      r.idx_y <= crs_pkg::RST_BYTE;
      r.fetch_hi <= crs_pkg::RST_FETCH_HI; // see RULE_13
      r.fetch_lo <= crs_pkg::RST_FETCH_LO; // see RULE_13
      r.flags <= crs_pkg::RST_BYTE;
      r.ea <= crs_pkg::RST_WORD;
      r.stk_addr <= crs_pkg::RST_WORD;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= 32'h0;
    end else begin
      r <= next_r;
    end
  end

  // Stack pointer and stack page carry no reset at all.
  always_ff @(posedge pclk) begin
    stack_ptr <= next_stack_ptr; // see RULE_10
    for (int i = 0; i < 3; i++) begin
      if (stk_we[i]) begin
        stack_mem[stk_wa[i]] <= stk_wd[i]; // see RULE_06
      end
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign pair_word_reg = {r.idx_y, r.work}; // see RULE_03
  assign next_fetch_addr = {r.fetch_hi, r.fetch_lo};
  assign flag_word = r.flags;
  assign eff_addr = r.ea;
  assign stk_addr = r.stk_addr;

endmodule : crs_register_set

// ### tb/crs_register_set_checker.sv
/*
  Checker of the register set: relations between APB traffic and outputs.
  Assumes it is bound to crs_register_set and sees only its ports.
*/
`timescale 1ns/100ps
module crs_register_set_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] pair_word_reg,
  input wire logic [15:0] next_fetch_addr,
  input wire logic [7:0] flag_word,
  input wire logic [15:0] eff_addr,
  input wire logic [15:0] stk_addr
);
  logic wr;
  logic cmd;
  logic [4:0] op;
  // Completed write, completed command write and its operation code.
  assign wr = psel && penable && pready && pwrite;
  assign cmd = wr && (paddr == crs_pkg::OFF_CMD);
  assign op = pwdata[4:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst_fetch;
    $rose(presetn) |-> next_fetch_addr == 16'hfffe && flag_word == 8'h00;
  endproperty
  a_rst_fetch: assert property (p_rst_fetch)
    else $error("fetch address not at reset value");
  property p_pair;
    wr && paddr == crs_pkg::OFF_PAIR |=> pair_word_reg == $past(pwdata[15:0]);
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair word differs from written word");
  property p_fetch_hi;
    wr && paddr == crs_pkg::OFF_FETCH_HI |=> next_fetch_addr ==
      {$past(pwdata[7:0]), $past(next_fetch_addr[7:0])};
  endproperty
  a_fetch_hi: assert property (p_fetch_hi)
    else $error("fetch high half write wrong");
  property p_page;
    $changed(stk_addr) |-> stk_addr[15:8] == 8'h01;
  endproperty
  a_page: assert property (p_page)
    else $error("stack access outside page one");
  property p_call;
    cmd && op == crs_pkg::OP_CALL |=> next_fetch_addr == $past(pwdata[31:16]);
  endproperty
  a_call: assert property (p_call)
    else $error("call did not load fetch address");
  property p_irq_on;
    cmd && op == crs_pkg::OP_IRQ_ON |=> flag_word[crs_pkg::FLG_I];
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("interrupt enable not set");
  property p_irq_clr;
    cmd && (op == crs_pkg::OP_IRQ_OFF || op == crs_pkg::OP_IRQ)
      |=> !flag_word[crs_pkg::FLG_I];
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt enable not cleared");
  property p_bit;
    cmd && op == crs_pkg::OP_BIT |=> flag_word[7:6] == $past(pwdata[15:14]);
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit test flags wrong");
  property p_ld;
    cmd && op == crs_pkg::OP_LD |=> flag_word[1] == ($past(pwdata[15:8]) ==
      8'h00) && flag_word[7] == $past(pwdata[15]);
  endproperty
  a_ld: assert property (p_ld)
    else $error("load flags wrong");
endmodule : crs_register_set_checker

bind crs_register_set crs_register_set_checker chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .pair_word_reg, .next_fetch_addr, .flag_word, .eff_addr, .stk_addr);

// ### tb/crs_register_set_test.sv
/*
  Self-checking bench of the register set, driven over APB.
  Assumes the checker is bound and the clock is 40 MHz.
*/
`timescale 1ns/100ps
module crs_register_set_test;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [7:0] paddr, flag_word;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  logic [15:0] pair_word_reg, next_fetch_addr, eff_addr, stk_addr;
  int fail_count, num_checks, cyc;

  crs_register_set dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pair_word_reg, .next_fetch_addr,
    .flag_word, .eff_addr, .stk_addr);

  // Clock of 25 ns.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Watchdog ends a hung run.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the ready edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk({err, rd}, {1'b0, exp});
  endtask : rchk

  task cmd(input crs_pkg::crs_op_e op, input logic [1:0] s,
      input logic [7:0] i, input logic [15:0] a);
    wr(crs_pkg::OFF_CMD, {a, i, 1'b0, s, op});
  endtask : cmd

  task rst;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst

  // Main sequence of tests.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    rst();
    chk(next_fetch_addr, 16'hfffe);
    rchk(crs_pkg::OFF_FETCH_HI, 32'hff);
    rchk(crs_pkg::OFF_FETCH_LO, 32'hfe);
    wr(crs_pkg::OFF_WORK, 32'h34);
    wr(crs_pkg::OFF_IDX_Y, 32'h12);
    chk(pair_word_reg, 16'h1234);
    wr(crs_pkg::OFF_PAIR, 32'habcd);
    rchk(crs_pkg::OFF_WORK, 32'hcd);
    rchk(crs_pkg::OFF_IDX_Y, 32'hab);
    wr(crs_pkg::OFF_IDX_X, 32'h10);
    cmd(crs_pkg::OP_INDEX, crs_pkg::SEL_IDX_X, 8'h00, 16'h2000);
    chk(eff_addr, 16'h2010);
    cmd(crs_pkg::OP_INDEX, crs_pkg::SEL_IDX_Y, 8'h00, 16'h2ff0);
    rchk(crs_pkg::OFF_EA, 32'h309b);
    cmd(crs_pkg::OP_LD, crs_pkg::SEL_IDX_X, 8'hff, 16'h0);
    cmd(crs_pkg::OP_INC, crs_pkg::SEL_IDX_X, 8'h00, 16'h0);
    rchk(crs_pkg::OFF_IDX_X, 32'h00);
    chk(flag_word[1], 1'b1);
    cmd(crs_pkg::OP_DEC, crs_pkg::SEL_IDX_X, 8'h00, 16'h0);
    rchk(crs_pkg::OFF_IDX_X, 32'hff);
    chk(flag_word[7], 1'b1);
    cmd(crs_pkg::OP_CMP, crs_pkg::SEL_IDX_X, 8'hff, 16'h0);
    chk(flag_word[1:0], 2'b11);
    // Add, subtract, shift, rotate and bit test on the work register, then interrupt enable on and off.
    wr(crs_pkg::OFF_FLAGS, 32'h0);
    wr(crs_pkg::OFF_WORK, 32'h7f);
    cmd(crs_pkg::OP_ADC, crs_pkg::SEL_WORK, 8'h01, 16'h0);
    chk(flag_word, 8'hc8);
    cmd(crs_pkg::OP_ADC, crs_pkg::SEL_WORK, 8'h80, 16'h0);
    chk(flag_word, 8'h43);
    cmd(crs_pkg::OP_CLRV, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk(flag_word, 8'h03);
    cmd(crs_pkg::OP_SBC, crs_pkg::SEL_WORK, 8'h01, 16'h0);
    chk(flag_word, 8'h80);
    rchk(crs_pkg::OFF_WORK, 32'hff);
    cmd(crs_pkg::OP_ASL, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk({flag_word[7], flag_word[1:0]}, 3'b101);
    cmd(crs_pkg::OP_ROR, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk({flag_word[7], flag_word[1:0]}, 3'b100);
    cmd(crs_pkg::OP_BIT, crs_pkg::SEL_WORK, 8'h40, 16'h0);
    chk(flag_word[7:6], 2'b01);
    cmd(crs_pkg::OP_IRQ_ON, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk(flag_word[2], 1'b1);
    cmd(crs_pkg::OP_IRQ_OFF, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk(flag_word[2], 1'b0);
    // Stack page traffic after the usual pointer set-up.
    wr(crs_pkg::OFF_STACK, 32'hff);
    wr(crs_pkg::OFF_WORK, 32'h5a);
    cmd(crs_pkg::OP_PUSH, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk(stk_addr, 16'h01ff);
    rchk(crs_pkg::OFF_STK_ADDR, 32'h01ff);
    rchk(crs_pkg::OFF_STACK, 32'hfe);
    wr(crs_pkg::OFF_WORK, 32'h0);
    cmd(crs_pkg::OP_POP, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    rchk(crs_pkg::OFF_WORK, 32'h5a);
    rchk(crs_pkg::OFF_STACK, 32'hff);
    cmd(crs_pkg::OP_CALL, crs_pkg::SEL_WORK, 8'h00, 16'h1234);
    chk(next_fetch_addr, 16'h1234);
    rchk(crs_pkg::OFF_STACK, 32'hfd);
    cmd(crs_pkg::OP_RET, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk(next_fetch_addr, 16'hfffe);
    cmd(crs_pkg::OP_IRQ_ON, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    cmd(crs_pkg::OP_IRQ, crs_pkg::SEL_WORK, 8'h00, 16'hfffc);
    chk(flag_word[2], 1'b0);
    rchk(crs_pkg::OFF_STACK, 32'hfc);
    cmd(crs_pkg::OP_RETI, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    chk(flag_word[2], 1'b1);
    rchk(crs_pkg::OFF_STACK, 32'hff);
    cmd(crs_pkg::OP_BRK, crs_pkg::SEL_WORK, 8'h00, 16'hfff0);
    chk(flag_word[4], 1'b1);
    // Word load and word increment on the pair.
    cmd(crs_pkg::OP_LDW, crs_pkg::SEL_WORK, 8'h00, 16'h12ff);
    chk(pair_word_reg, 16'h12ff);
    cmd(crs_pkg::OP_INCW, crs_pkg::SEL_WORK, 8'h00, 16'h0);
    rchk(crs_pkg::OFF_PAIR, 32'h1300);
    // Unmapped read and a write to a read-only place.
    xfer(1'b0, 8'h40, 32'h0);
    chk({err, rd}, 33'h1_0000_0000);
    wr(crs_pkg::OFF_EA, 32'hffff);
    rchk(crs_pkg::OFF_EA, 32'h309b);
    // A second reset must leave the stack pointer alone.
    wr(crs_pkg::OFF_STACK, 32'h80);
    wr(crs_pkg::OFF_FETCH_HI, 32'h12);
    wr(crs_pkg::OFF_FETCH_LO, 32'h00);
    chk(next_fetch_addr, 16'h1200);
    rst();
    rchk(crs_pkg::OFF_STACK, 32'h80);
    chk(next_fetch_addr, 16'hfffe);
    close_out();
  end
endmodule : crs_register_set_test
